/* File: hdl/bcmc_defs.svh */
/*
 constants for the bit-count, move and compare unit: word widths, flag positions, flag reset value, pc mask.
 assumes the decoder presents one operation per cycle with operands already read.
*/
`ifndef BCMC_DEFS_SVH
`define BCMC_DEFS_SVH
`define BCMC_WORD_W      32
`define BCMC_HALF_W      16
`define BCMC_FLAG_N      3
`define BCMC_FLAG_Z      2
`define BCMC_FLAG_C      1
`define BCMC_FLAG_V      0
`define BCMC_FLAGS_RESET 4'h0
`define BCMC_PC_LSB_MASK 32'hffff_fffe
`endif

/* File: hdl/bcmc_pkg.sv */
/*
 types for the bit-count, move and compare unit.
 assumes nothing beyond the defs header.
*/
package bcmc_pkg;
   typedef enum logic [3:0] {
      op_leading_zero_count,
      op_compare_subtract,
      op_compare_add,
      op_register_copy,
      op_inverted_copy,
      op_wide_immediate_copy,
      op_top_half_load,
      op_word_byte_swap,
      op_halfword_byte_swap,
      op_signed_half_byte_swap,
      op_bit_mirror
   } op_e;
   typedef enum logic [2:0] {
      sh_lsl,
      sh_lsr,
      sh_asr,
      sh_ror,
      sh_rrx
   } shift_e;
endpackage

/* File: hdl/bcmc_shifter.sv */
/*
 operand shifter for the flexible second operand; yields value and shifter carry.
 assumes shift amount is the low byte of the shift register or an immediate; combinational.
*/
`timescale 1ns/1ps
`include "bcmc_defs.svh"
module bcmc_shifter
(
   input  wire logic [31:0]      value_in,
   input  wire bcmc_pkg::shift_e kind,
   input  wire logic [7:0]       amount,
   input  wire logic             carry_in,
   output logic      [31:0]      value_out,
   output logic                  carry_out
);
   logic [63:0] wide;
   logic [4:0]  rot;
   always_comb
   begin
      value_out = value_in;
      carry_out = carry_in;
      wide      = 64'h0;
      rot       = amount[4:0];
      // amount 0 passes value and keeps carry for lsl, lsr, asr and ror; rrx ignores amount
      case (kind)
         bcmc_pkg::sh_lsl:
         begin
            if (amount != 8'h00)
            begin
               wide      = {32'h0, value_in} << amount;
               value_out = wide[31:0];
               carry_out = (amount > 8'h20) ? 1'b0 : wide[32];
            end
         end
         bcmc_pkg::sh_lsr:
         begin
            if (amount != 8'h00)
            begin
               wide      = {value_in, 32'h0} >> amount;
               value_out = wide[63:32];
               carry_out = (amount > 8'h20) ? 1'b0 : wide[31];
            end
         end
         bcmc_pkg::sh_asr:
         begin
            if (amount != 8'h00)
            begin
               wide      = $signed({value_in, 32'h0}) >>> ((amount > 8'h20) ? 8'h20 : amount);
               value_out = wide[63:32];
               carry_out = wide[31];
            end
         end
         bcmc_pkg::sh_ror:
         begin
            if (amount != 8'h00)
            begin
               wide      = {value_in, value_in} >> rot;
               value_out = wide[31:0];
               carry_out = wide[31];
            end
         end
         default:
         begin
            value_out = {carry_in, value_in[31:1]};
            carry_out = value_in[0];
         end
      endcase
   end
endmodule

/* File: hdl/bcmc_unit.sv */
/*
 bit-count, move and compare unit: one operation issued per cycle, result and flags registered.
 assumes decoder supplies operands, condition pass and flag request; register file takes writes.
*/
`timescale 1ns/1ps
`include "bcmc_defs.svh"
module bcmc_unit
(
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic             issue,
   input  wire bcmc_pkg::op_e    op,
   input  wire logic             cond_pass,
   input  wire logic             set_flags,
   input  wire logic             dest_is_pc,
   input  wire logic [31:0]      first_operand_reg,
   input  wire logic [31:0]      source_reg,
   input  wire logic             use_immediate,
   input  wire logic [31:0]      immediate_value,
   input  wire bcmc_pkg::shift_e shift_kind,
   input  wire logic [7:0]       shift_amount,
   input  wire logic [15:0]      sixteen_bit_immediate,
   input  wire logic [31:0]      dest_old_value,
   output logic                  result_valid_q,
   output logic [31:0]           result_q,
   output logic                  branch_q,
   output logic [31:0]           branch_target_q,
   output logic [3:0]            flags_q
);
   logic [31:0] flexible_second_operand;
   logic        shifter_carry;
   logic [31:0] shifted;
   logic        result_valid_d;
   logic [31:0] result_d;
   logic        branch_d;
   logic [31:0] branch_target_d;
   logic [3:0]  flags_d;
   logic [32:0] arith;
   logic [31:0] res;

   bcmc_shifter u_shifter
   (
      .value_in  (source_reg),
      .kind      (shift_kind),
      .amount    (shift_amount),
      .carry_in  (flags_q[`BCMC_FLAG_C]),
      .value_out (shifted),
      .carry_out (shifter_carry)
   );

   function automatic logic [5:0] count_leading(input logic [31:0] v);
      logic [5:0] n;
      logic       hit;
      n   = 6'd32;
      hit = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         if (!hit && v[i])
         begin
            n   = 6'(31 - i);
            hit = 1'b1;
         end
      end
      return n;
   endfunction

   function automatic logic [31:0] mirror(input logic [31:0] v);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 32; i++)
      begin
         r[31 - i] = v[i];
      end
      return r;
   endfunction

   always_comb
   begin
      flexible_second_operand = use_immediate ? immediate_value : shifted;
      result_valid_d          = 1'b0;
      result_d                = result_q;
      branch_d                = 1'b0;
      branch_target_d         = branch_target_q;
      flags_d                 = flags_q;
      arith                   = 33'h0;
      res                     = 32'h0;
      if (issue && cond_pass) // failed condition touches nothing
      begin
         case (op)
            bcmc_pkg::op_leading_zero_count:
            begin
               res = {26'h0, count_leading(source_reg)};
               result_valid_d = 1'b1;
            end
            bcmc_pkg::op_compare_subtract, bcmc_pkg::op_compare_add:
            begin
               // carry on subtract is not-borrow, as a flag-setting subtract gives
               if (op == bcmc_pkg::op_compare_subtract)
                  arith = {1'b0, first_operand_reg} + {1'b0, ~flexible_second_operand}
                          + 33'h1;
               else
                  arith = {1'b0, first_operand_reg} + {1'b0, flexible_second_operand};
               flags_d[`BCMC_FLAG_N] = arith[31];
               flags_d[`BCMC_FLAG_Z] = (arith[31:0] == 32'h0);
               flags_d[`BCMC_FLAG_C] = arith[32];
               if (op == bcmc_pkg::op_compare_subtract)
                  flags_d[`BCMC_FLAG_V] = (first_operand_reg[31] != flexible_second_operand[31])
                                          && (arith[31] != first_operand_reg[31]);
               else
                  flags_d[`BCMC_FLAG_V] = (first_operand_reg[31] == flexible_second_operand[31])
                                          && (arith[31] != first_operand_reg[31]);
            end
            bcmc_pkg::op_register_copy, bcmc_pkg::op_inverted_copy,
            bcmc_pkg::op_wide_immediate_copy:
            begin
               if (op == bcmc_pkg::op_wide_immediate_copy)
                  res = {16'h0, sixteen_bit_immediate};
               else if (op == bcmc_pkg::op_inverted_copy)
                  res = ~flexible_second_operand;
               else
                  res = flexible_second_operand;
               if (set_flags) // without request flags hold
               begin
                  flags_d[`BCMC_FLAG_N] = res[31];
                  flags_d[`BCMC_FLAG_Z] = (res == 32'h0);
                  if (!use_immediate && op != bcmc_pkg::op_wide_immediate_copy)
                     flags_d[`BCMC_FLAG_C] = shifter_carry;
               end
               if (dest_is_pc && op == bcmc_pkg::op_register_copy)
               begin
                  branch_d        = 1'b1;
                  branch_target_d = res & `BCMC_PC_LSB_MASK;
               end
               else
                  result_valid_d = 1'b1;
            end
            bcmc_pkg::op_top_half_load:
            begin
               res = {sixteen_bit_immediate, dest_old_value[15:0]};
               result_valid_d = 1'b1;
            end
            bcmc_pkg::op_word_byte_swap:
            begin
               res = {source_reg[7:0], source_reg[15:8],
                      source_reg[23:16], source_reg[31:24]};
               result_valid_d = 1'b1;
            end
            bcmc_pkg::op_halfword_byte_swap:
            begin
               res = {source_reg[23:16], source_reg[31:24],
                      source_reg[7:0], source_reg[15:8]};
               result_valid_d = 1'b1;
            end
            bcmc_pkg::op_signed_half_byte_swap:
            begin
               res = {{16{source_reg[7]}}, source_reg[7:0], source_reg[15:8]};
               result_valid_d = 1'b1;
            end
            bcmc_pkg::op_bit_mirror:
            begin
               res = mirror(source_reg);
               result_valid_d = 1'b1;
            end
            default:
            begin
               res = 32'h0;
            end
         endcase
         if (result_valid_d)
            result_d = res;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         result_valid_q  <= 1'b0;
         result_q        <= 32'h0;
         branch_q        <= 1'b0;
         branch_target_q <= 32'h0;
         flags_q         <= `BCMC_FLAGS_RESET;
      end
      else
      begin
         result_valid_q  <= result_valid_d;
         result_q        <= result_d;
         branch_q        <= branch_d;
         branch_target_q <= branch_target_d;
         flags_q         <= flags_d;
      end
   end

   property p_clz_zero;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && cond_pass && op == bcmc_pkg::op_leading_zero_count && source_reg == 32'h0
      |=> result_valid_q && result_q == 32'd32;
   endproperty
   a_clz_zero: assert property (p_clz_zero) else $error("zero operand count not 32");

   property p_clz_msb;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && cond_pass && op == bcmc_pkg::op_leading_zero_count && source_reg[31]
      |=> result_q == 32'd0;
   endproperty
   a_clz_msb: assert property (p_clz_msb) else $error("msb set count not 0");

   property p_cmp_no_write;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && (op == bcmc_pkg::op_compare_subtract || op == bcmc_pkg::op_compare_add)
      |=> !result_valid_q && !branch_q;
   endproperty
   a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote a result");

   property p_cmp_zero;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && cond_pass && op == bcmc_pkg::op_compare_subtract && use_immediate
      && immediate_value == first_operand_reg
      |=> flags_q[`BCMC_FLAG_Z] && flags_q[`BCMC_FLAG_C] && !flags_q[`BCMC_FLAG_V];
   endproperty
   a_cmp_zero: assert property (p_cmp_zero) else $error("equal compare flags wrong");

   property p_fail_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && !cond_pass |=> !result_valid_q && !branch_q && $stable(flags_q);
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("failed condition had effect");

   property p_swap_flags;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && (op == bcmc_pkg::op_word_byte_swap || op == bcmc_pkg::op_bit_mirror
      || op == bcmc_pkg::op_leading_zero_count || op == bcmc_pkg::op_top_half_load)
      |=> $stable(flags_q);
   endproperty
   a_swap_flags: assert property (p_swap_flags) else $error("flags changed");

   property p_top_half_load_low;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && cond_pass && op == bcmc_pkg::op_top_half_load
      |=> result_q[15:0] == $past(dest_old_value[15:0])
          && result_q[31:16] == $past(sixteen_bit_immediate);
   endproperty
   a_top_half_load_low: assert property (p_top_half_load_low) else $error("top-half load wrong");

   property p_pc_branch;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && cond_pass && op == bcmc_pkg::op_register_copy && dest_is_pc
      |=> branch_q && !branch_target_q[0] && !result_valid_q;
   endproperty
   a_pc_branch: assert property (p_pc_branch) else $error("pc copy not branched");

   property p_copy_v;
      @(posedge sys_clk) disable iff (!reset_n)
      issue && (op == bcmc_pkg::op_register_copy || op == bcmc_pkg::op_inverted_copy)
      |=> $stable(flags_q[`BCMC_FLAG_V]);
   endproperty
   a_copy_v: assert property (p_copy_v) else $error("copy changed overflow");
endmodule

/* File: sim/regfile_model.sv */
/*
 register file model: one destination register, fed back as its old value.
 assumes writes arrive as result_valid_q with result_q from the unit.
*/
`timescale 1ns/1ps
module regfile_model
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] dest_value
);
   // no forwarding here: the caller leaves one idle cycle before a dependent op
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         dest_value <= 32'h0;
      else if (wr_en)
         dest_value <= wr_data;
   end
endmodule

/* File: sim/testbench.sv */
/*
 self-checking bench for the bit-count, move and compare unit.
 assumes one answer per issue on the next edge; inputs change 1 ns after the edge.
*/
`timescale 1ns/1ps
module testbench;
   logic             sys_clk = 1'b0;
   logic             reset_n = 1'b0;
   logic             issue = 1'b0;
   bcmc_pkg::op_e    op = bcmc_pkg::op_leading_zero_count;
   logic             cond_pass = 1'b1;
   logic             set_flags = 1'b0;
   logic             dest_is_pc = 1'b0;
   logic             use_immediate = 1'b1;
   logic [31:0]      first_operand_reg = 32'h0;
   logic [31:0]      source_reg = 32'h0;
   logic [31:0]      immediate_value = 32'h0;
   bcmc_pkg::shift_e shift_kind = bcmc_pkg::sh_lsl;
   logic [7:0]       shift_amount = 8'h0;
   logic [15:0]      sixteen_bit_immediate = 16'h0;
   logic [31:0]      dest_old_value;
   logic             result_valid_q;
   logic [31:0]      result_q;
   logic             branch_q;
   logic [31:0]      branch_target_q;
   logic [3:0]       flags_q;
   int               err_count = 0;
   int               total_checks = 0;

   always #2.5 sys_clk = ~sys_clk;

   bcmc_unit bcmc_unit_inst (.sys_clk(sys_clk), .reset_n(reset_n), .issue(issue), .op(op),
      .cond_pass(cond_pass), .set_flags(set_flags), .dest_is_pc(dest_is_pc),
      .first_operand_reg(first_operand_reg), .source_reg(source_reg),
      .use_immediate(use_immediate), .immediate_value(immediate_value),
      .shift_kind(shift_kind), .shift_amount(shift_amount),
      .sixteen_bit_immediate(sixteen_bit_immediate), .dest_old_value(dest_old_value),
      .result_valid_q(result_valid_q), .result_q(result_q), .branch_q(branch_q),
      .branch_target_q(branch_target_q), .flags_q(flags_q));

   regfile_model regfile_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
      .wr_en(result_valid_q), .wr_data(result_q), .dest_value(dest_old_value));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one issue cycle, answer read one edge later, then the pulse must be gone
   task go(input bcmc_pkg::op_e o, input logic [31:0] s, input logic [31:0] er,
           input logic [31:0] ev, input logic [3:0] ef);
      op = o;
      source_reg = s;
      issue = 1'b1;
      @(posedge sys_clk) #1;
      issue = 1'b0;
      chk({31'h0, result_valid_q}, ev);
      if (ev != 32'h0)
         chk(result_q, er);
      chk({31'h0, branch_q}, {31'h0, dest_is_pc});
      if (dest_is_pc)
         chk(branch_target_q, s & 32'hffff_fffe);
      chk({28'h0, flags_q}, {28'h0, ef});
      @(posedge sys_clk) #1;
      chk({31'h0, result_valid_q}, 32'h0);
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      chk({28'h0, flags_q}, 32'h0);
      immediate_value = 32'h2;
      first_operand_reg = 32'h1;
      go(bcmc_pkg::op_compare_subtract, 0, 0, 0, 4'h8);
      first_operand_reg = 32'h8000_0000;
      immediate_value = 32'h1;
      go(bcmc_pkg::op_compare_subtract, 0, 0, 0, 4'h3);
      first_operand_reg = 32'hffff_ffff;
      go(bcmc_pkg::op_compare_add, 0, 0, 0, 4'h6);
      first_operand_reg = 32'h1;
      go(bcmc_pkg::op_compare_subtract, 0, 0, 0, 4'h6);
      first_operand_reg = 32'h7fff_ffff;
      go(bcmc_pkg::op_compare_add, 0, 0, 0, 4'h9);
      cond_pass = 1'b0;
      go(bcmc_pkg::op_compare_subtract, 0, 0, 0, 4'h9);
      go(bcmc_pkg::op_register_copy, 32'h5, 0, 0, 4'h9);
      cond_pass = 1'b1;
      $display("test compares done");
      use_immediate = 1'b0;
      go(bcmc_pkg::op_leading_zero_count, 0, 32, 1, 4'h9);
      go(bcmc_pkg::op_leading_zero_count, 32'h8000_0000, 0, 1, 4'h9);
      go(bcmc_pkg::op_leading_zero_count, 32'h00ff_0000, 8, 1, 4'h9);
      go(bcmc_pkg::op_leading_zero_count, 32'h1, 31, 1, 4'h9);
      $display("test count done");
      set_flags = 1'b1;
      shift_kind = bcmc_pkg::sh_lsr;
      shift_amount = 8'h1;
      go(bcmc_pkg::op_register_copy, 32'h8000_0000, 32'h4000_0000, 1, 4'h1);
      shift_kind = bcmc_pkg::sh_lsl;
      go(bcmc_pkg::op_register_copy, 32'h8000_0001, 32'h2, 1, 4'h3);
      // carry is set here, so the extended rotate must pull it into bit 31
      shift_kind = bcmc_pkg::sh_rrx;
      go(bcmc_pkg::op_register_copy, 32'h2, 32'h8000_0001, 1, 4'h9);
      shift_kind = bcmc_pkg::sh_asr;
      shift_amount = 8'h4;
      go(bcmc_pkg::op_register_copy, 32'h8000_0000, 32'hf800_0000, 1, 4'h9);
      set_flags = 1'b0;
      shift_kind = bcmc_pkg::sh_ror;
      shift_amount = 8'h8;
      go(bcmc_pkg::op_register_copy, 32'h1234_5678, 32'h7812_3456, 1, 4'h9);
      go(bcmc_pkg::op_inverted_copy, 32'h9abc_de78, 32'h8765_4321, 1, 4'h9);
      set_flags = 1'b1;
      use_immediate = 1'b1;
      immediate_value = 32'hffff_ffff;
      go(bcmc_pkg::op_inverted_copy, 0, 32'h0, 1, 4'h5);
      $display("test copies done");
      use_immediate = 1'b0;
      shift_amount = 8'h0;
      set_flags = 1'b0;
      dest_is_pc = 1'b1;
      go(bcmc_pkg::op_register_copy, 32'h1235, 32'h1235, 0, 4'h5);
      dest_is_pc = 1'b0;
      sixteen_bit_immediate = 16'hbeef;
      go(bcmc_pkg::op_wide_immediate_copy, 0, 32'h0000_beef, 1, 4'h5);
      set_flags = 1'b1;
      sixteen_bit_immediate = 16'hdead;
      go(bcmc_pkg::op_top_half_load, 0, 32'hdead_beef, 1, 4'h5);
      $display("test immediates done");
      go(bcmc_pkg::op_word_byte_swap, 32'h12b4_56f8, 32'hf856_b412, 1, 4'h5);
      go(bcmc_pkg::op_halfword_byte_swap, 32'h12b4_56f8, 32'hb412_f856, 1, 4'h5);
      go(bcmc_pkg::op_signed_half_byte_swap, 32'h12b4_56f8, 32'hffff_f856, 1, 4'h5);
      go(bcmc_pkg::op_signed_half_byte_swap, 32'h0000_1234, 32'h0000_3412, 1, 4'h5);
      go(bcmc_pkg::op_bit_mirror, 32'h0000_0003, 32'hc000_0000, 1, 4'h5);
      $display("test reversals done");
      tally_and_finish();
   end
endmodule
